// ===== dv/vpd_monitor_tb.sv
/*
  Self-checking bench for the path defect monitor: frames come from the
  source model, registers are reached through the processor port tasks.
  Assumes the register map and reset values of vpd_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module vpd_monitor_tb;
  import vpd_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cs = 1'b0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [5:0] evt = 6'h00;
  wire logic frame, pv, new_data_flag, ones;
  wire logic [7:0] c2, g1;
  logic [7:0] rdata, v, lbl, seed = 8'h04;
  logic [5:0] defect, e;
  int bad_count = 0;
  int checked = 0;
  logic [15:0] offs [6] = '{OFF_INT_STAT2, OFF_DEFECT_STAT0, OFF_RDI_CFG, OFF_RX_LABEL,
                            OFF_EXP_LABEL, 16'h1000};
  logic [7:0] rstv [6] = '{RST_INT_STAT2, 8'h00, RST_RDI_CFG, RST_RX_LABEL,
                           RST_EXP_LABEL, 8'h00};
  logic [7:0] codes [3] = '{8'h04, 8'h0a, 8'h0c};

  always #12.5 mclk = ~mclk;

  vpd_source vpd_source_i (.mclk_i(mclk), .frame_o(frame), .c2_o(c2), .g1_o(g1),
    .ptr_valid_o(pv), .ndf_set_o(new_data_flag), .ptr_ones_o(ones));

  vpd_monitor vpd_monitor_i (.mclk_i(mclk), .rst_i(rst), .frame_i(frame), .c2_i(c2),
    .g1_i(g1), .ptr_valid_i(pv), .ndf_set_i(new_data_flag), .ptr_ones_i(ones), .h3_ones_i(ones),
    .spe_ones_i(ones), .ptr_change_i(evt[3]), .poh_capture_i(evt[2]),
    .concat_alarm_chg_i(evt[5]), .concat_ptr_loss_chg_i(evt[4]),
    .trace_mismatch_chg_i(evt[1]), .trace_unstable_chg_i(evt[0]), .cs_i(cs),
    .rd_i(rd_en), .wr_i(wr_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .defect_o(defect));

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    cs = 1'b1;
    rd_en = 1'b1;
    addr = a;
    @(negedge mclk);
    cs = 1'b0;
    rd_en = 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    cs = 1'b1;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk);
    cs = 1'b0;
    wr_en = 1'b0;
    @(negedge mclk);
  endtask

  task automatic fr(input int n, input logic [7:0] c, input logic [7:0] g, input logic p,
                    input logic f, input logic o);
    repeat (n) begin
      seed = nxt(seed);
      vpd_source_i.send(c, g, p, f, o, 1 + int'(seed[1:0]));
    end
    repeat (4) @(negedge mclk);
  endtask

  task automatic st(input logic [7:0] m, input logic [7:0] x);
    rd_reg(OFF_DEFECT_STAT0, v);
    chk(v & m, x);
    chk({2'b00, defect} & m, x);
  endtask

  task automatic stop_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    bad_count++;
    stop_test;
  end

  initial begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    for (int i = 0; i < 6; i++) begin
      rd_reg(offs[i], v);
      chk(v, rstv[i]);
    end
    lbl = {seed[6:0], 1'b1};
    fr(4, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    rd_reg(OFF_RX_LABEL, v);
    chk(v, 8'h00);
    fr(1, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    rd_reg(OFF_RX_LABEL, v);
    chk(v, lbl);
    st(8'hff, 8'h10);
    wr_reg(OFF_RX_LABEL, 8'h00);
    rd_reg(OFF_RX_LABEL, v);
    chk(v, lbl);
    wr_reg(OFF_EXP_LABEL, lbl);
    rd_reg(OFF_EXP_LABEL, v);
    chk(v, lbl);
    fr(1, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    st(8'hff, 8'h00);
    fr(4, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
    st(8'hff, 8'h00);
    fr(1, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
    st(8'hff, 8'h20);
    fr(4, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    st(8'h20, 8'h20);
    fr(1, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    st(8'hff, 8'h00);
    wr_reg(OFF_EXP_LABEL, 8'h00);
    fr(6, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
    st(8'hff, 8'h00);
    wr_reg(OFF_EXP_LABEL, lbl);
    fr(5, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    st(8'hff, 8'h00);
    // Threshold three, single-bit mode
    wr_reg(OFF_RDI_CFG, 8'h03);
    rd_reg(OFF_RDI_CFG, v);
    chk(v, 8'h03);
    fr(2, lbl, 8'h08, 1'b1, 1'b0, 1'b0);
    st(8'hff, 8'h00);
    fr(1, lbl, 8'h08, 1'b1, 1'b0, 1'b0);
    st(8'hff, 8'h08);
    fr(3, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    st(8'hff, 8'h00);
    wr_reg(OFF_RDI_CFG, 8'h13);
    for (int i = 0; i < 3; i++) begin
      fr(3, lbl, codes[i], 1'b1, 1'b0, 1'b0);
      st(8'h08, 8'h08);
      fr(3, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
      st(8'h08, 8'h00);
    end
    fr(3, lbl, 8'h08, 1'b1, 1'b0, 1'b0);
    st(8'h08, 8'h00);
    fr(3, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    wr_reg(OFF_RDI_CFG, 8'h03);
    fr(1, lbl, 8'h08, 1'b1, 1'b0, 1'b0);
    fr(1, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    fr(1, lbl, 8'h08, 1'b1, 1'b0, 1'b0);
    st(8'h04, 8'h04);
    fr(2, lbl, 8'h08, 1'b1, 1'b0, 1'b0);
    st(8'h04, 8'h00);
    fr(3, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    fr(7, lbl, 8'h00, 1'b0, 1'b0, 1'b0);
    st(8'h02, 8'h00);
    fr(1, lbl, 8'h00, 1'b0, 1'b0, 1'b0);
    st(8'hff, 8'h02);
    fr(2, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    st(8'h02, 8'h02);
    fr(1, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    st(8'h02, 8'h00);
    fr(7, lbl, 8'h00, 1'b1, 1'b1, 1'b0);
    st(8'h02, 8'h00);
    fr(1, lbl, 8'h00, 1'b1, 1'b1, 1'b0);
    st(8'h02, 8'h02);
    fr(3, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    rd_reg(OFF_INT_STAT2, v);
    fr(2, lbl, 8'h00, 1'b0, 1'b0, 1'b1);
    st(8'h01, 8'h00);
    fr(8, lbl, 8'h00, 1'b0, 1'b0, 1'b1);
    st(8'hff, 8'h01);
    rd_reg(OFF_INT_STAT2, v);
    chk(v, 8'h10);
    fr(2, lbl, 8'h00, 1'b1, 1'b1, 1'b0);
    st(8'h01, 8'h01);
    fr(1, lbl, 8'h00, 1'b1, 1'b1, 1'b0);
    st(8'h01, 8'h00);
    fr(3, lbl, 8'h00, 1'b1, 1'b0, 1'b0);
    st(8'hff, 8'h00);
    rd_reg(OFF_INT_STAT2, v);
    chk(v, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = nxt(seed);
      e = (i == 0) ? 6'h3f : seed[5:0];
      evt = e;
      @(negedge mclk);
      evt = 6'h00;
      wr_reg(OFF_INT_STAT2, 8'h00);
      rd_reg(OFF_INT_STAT2, v);
      chk(v, {1'b0, e[5:4], 1'b0, e[3:0]});
      rd_reg(OFF_INT_STAT2, v);
      chk(v, 8'h00);
    end
    // Event lands in the same cycle as the read
    evt = 6'h2a;
    cs = 1'b1;
    rd_en = 1'b1;
    addr = OFF_INT_STAT2;
    @(negedge mclk);
    evt = 6'h00;
    cs = 1'b0;
    rd_en = 1'b0;
    @(negedge mclk);
    rd_reg(OFF_INT_STAT2, v);
    chk(v, 8'h4a);
    rd_reg(OFF_INT_STAT2, v);
    chk(v, 8'h00);
    stop_test;
  end
endmodule
`default_nettype wire

// ===== dv/vpd_source.sv
/*
  Upstream path source model: presents one frame's overhead indications with
  each frame pulse, after a gap that the caller chooses.
  Assumes send is called from the bench's falling-edge driver.
*/
`timescale 1ns/100ps
`default_nettype none
module vpd_source (
  input wire logic mclk_i,
  output var logic frame_o,
  output var logic [7:0] c2_o,
  output var logic [7:0] g1_o,
  output var logic ptr_valid_o,
  output var logic ndf_set_o,
  output var logic ptr_ones_o
);
  initial begin
    frame_o = 1'b0;
    c2_o = 8'h00;
    g1_o = 8'h00;
    ptr_valid_o = 1'b1;
    ndf_set_o = 1'b0;
    ptr_ones_o = 1'b0;
  end

  task automatic send(input logic [7:0] c2, input logic [7:0] g1, input logic pv,
                      input logic new_data_flag, input logic ones, input int gap);
    repeat (gap) @(negedge mclk_i);
    frame_o = 1'b1;
    c2_o = c2;
    g1_o = g1;
    ptr_valid_o = pv;
    ndf_set_o = new_data_flag;
    ptr_ones_o = ones;
    @(negedge mclk_i);
    // Fields mean nothing outside the pulse, so scramble them
    frame_o = 1'b0;
    c2_o = ~c2;
    g1_o = ~g1;
    ptr_valid_o = ~pv;
    ndf_set_o = ~new_data_flag;
    ptr_ones_o = ~ones;
  endtask
endmodule
`default_nettype wire

// ===== rtl/vpd_label_check.sv
/*
  Signal label validation: a C2 value is accepted once it repeats in a run of
  consecutive frames; the accepted value is held in a register.
  Assumes frame_i pulses once per frame with c2_i valid in that cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module vpd_label_check
  import vpd_pkg::*;
#(
  parameter logic [3:0] PERSIST = LABEL_PERSIST
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic frame_i,
  input wire logic [7:0] c2_i,
  output logic [7:0] label_o,
  output logic accept_o
);
  logic [7:0] last_q;
  logic [3:0] run_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      last_q <= 8'h00;
      run_q <= 4'h0;
    end else if (frame_i) begin
      last_q <= c2_i;
      if (c2_i != last_q || run_q == 4'h0) begin
        run_q <= 4'h1;
      end else if (run_q < PERSIST) begin
        run_q <= run_q + 4'h1;
      end
    end
  end

  assign accept_o = frame_i && c2_i == last_q && run_q != 4'h0 && run_q + 4'h1 >= PERSIST;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      label_o <= RST_RX_LABEL;
    end else if (accept_o) begin
      label_o <= c2_i; // R4
    end
  end
endmodule
`default_nettype wire

// ===== rtl/vpd_monitor.sv
/*
  VC-4 path defect monitor: evaluates unequipped, label mismatch, remote
  defect, remote defect instability, pointer loss and AU alarm indication
  once per frame, and holds the 8-bit register bank for the processor port.
  Assumes the pointer interpreter supplies per-frame pointer and overhead
  indications, all sampled with frame_i, and the port is synchronous.
  // Function
  // R1: Declare unequipped after five consecutive frames with C2 equal to zero.
  // R2: Clear unequipped after five consecutive frames with nonzero C2.
  // R3: Never declare unequipped while the expected label is zero.
  // R4: Store C2 as received label after five identical consecutive frames.
  // R5: Mismatch while received label differs from expected; clear on match.
  // R6: Declaring unequipped clears any active mismatch.
  // R7: Single-bit mode: remote defect after threshold frames with G1 bit5 set.
  // R8: Enhanced mode: remote defect on codes 010, 101, 110 for threshold frames.
  // R9: Threshold comes from configuration bits 3 to 0, written by software.
  // R10: Count remote defect value changes; declare instability at threshold.
  // R11: Threshold frames of stable value reset counter and drop instability.
  // R12: Pointer loss after eight invalid pointers or eight new data flags.
  // R13: Clear pointer loss after three frames of valid pointer, normal flag.
  // R14: AU alarm when pointer bytes and payload all ones for three frames.
  // R15: Clear AU alarm after three frames of valid pointer, set or normal flag.
  // R16: All-ones pointer bytes give AU alarm rather than pointer loss.
  // R17: Status byte: bit5 unequipped, 4 mismatch, 3 remote, 2 unstable, 1 lop, 0 ais.
  // R18: Interrupt byte two latches events in bits 6 to 0; bit 7 reads zero.
  // R19: A configuration bit selects single-bit or enhanced remote defect mode.
  // R20: Interrupt bits read one since the last read and clear on reading.
  // R21: An event in the reading cycle stays latched for the next read.
  // R22: Defects update at frame boundary and all clear at reset.
*/
`timescale 1ns/100ps
`default_nettype none
module vpd_monitor
  import vpd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  // Frame-rate indications from pointer interpreter and overhead extractor
  input wire logic frame_i,
  input wire logic [7:0] c2_i,
  input wire logic [7:0] g1_i,
  input wire logic ptr_valid_i,
  input wire logic ndf_set_i,
  input wire logic ptr_ones_i,
  input wire logic h3_ones_i,
  input wire logic spe_ones_i,
  input wire logic ptr_change_i,
  input wire logic poh_capture_i,
  input wire logic concat_alarm_chg_i,
  input wire logic concat_ptr_loss_chg_i,
  input wire logic trace_mismatch_chg_i,
  input wire logic trace_unstable_chg_i,
  // Microprocessor port
  input wire logic cs_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [vpd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic [5:0] defect_o
);
  import vpd_pkg::*;

  logic [7:0] rdi_cfg_q;
  logic [7:0] exp_label_q;
  logic [7:0] int_stat_q;
  logic uneq_q, plm_q, rdi_q, rdiu_q, lop_q, ais_q;
  logic [2:0] rdi_val_q;
  logic [3:0] unst_q;
  logic [7:0] rx_label;
  logic label_accept;
  logic [3:0] thr;
  logic enh;
  logic [2:0] rdi_val;
  logic rdi_code;
  logic hit_zero, hit_nonzero, hit_rdi, hit_nordi, hit_same;
  logic hit_badptr, hit_ndf, hit_good, hit_ais, hit_aisclr;
  logic ptr_all_ones;
  logic rd_stat;
  logic [7:0] events;

  assign thr = rdi_cfg_q[RDI_THR_MSB:0]; // R9
  assign enh = rdi_cfg_q[RDI_TYPE_BIT]; // R19
  assign rdi_val = enh ? g1_i[3:1] : {2'b00, g1_i[3]};
  // G1 bit 5 is the MSB-numbered bit 5 (bit 1 = MSB), so bits 5..7 map to g1_i[3:1]
  assign rdi_code = enh ? (g1_i[3:1] == 3'b010 || g1_i[3:1] == 3'b101 ||
                           g1_i[3:1] == 3'b110) : g1_i[3]; // R7 R8
  assign ptr_all_ones = ptr_ones_i && h3_ones_i;

  vpd_label_check u_label (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .frame_i(frame_i),
    .c2_i(c2_i),
    .label_o(rx_label),
    .accept_o(label_accept)
  );

  vpd_persist #(.W(4)) u_zero (
    .mclk_i(mclk_i), .rst_i(rst_i), .frame_i(frame_i),
    .cond_i(c2_i == LABEL_UNEQ), .thr_i(LABEL_PERSIST), .hit_o(hit_zero)
  );
  vpd_persist #(.W(4)) u_nonzero (
    .mclk_i(mclk_i), .rst_i(rst_i), .frame_i(frame_i),
    .cond_i(c2_i != LABEL_UNEQ), .thr_i(LABEL_PERSIST), .hit_o(hit_nonzero)
  );
  vpd_persist #(.W(4)) u_rdi (
    .mclk_i(mclk_i), .rst_i(rst_i), .frame_i(frame_i),
    .cond_i(rdi_code), .thr_i(thr), .hit_o(hit_rdi)
  );
  vpd_persist #(.W(4)) u_nordi (
    .mclk_i(mclk_i), .rst_i(rst_i), .frame_i(frame_i),
    .cond_i(!rdi_code), .thr_i(thr), .hit_o(hit_nordi)
  );
  // A run of n equal frames gives n-1 equal adjacent pairs
  vpd_persist #(.W(4)) u_same (
    .mclk_i(mclk_i), .rst_i(rst_i), .frame_i(frame_i),
    .cond_i(rdi_val == rdi_val_q), .thr_i((thr == 4'h0) ? 4'h0 : thr - 4'h1), .hit_o(hit_same)
  );
  vpd_persist #(.W(4)) u_badptr (
    .mclk_i(mclk_i), .rst_i(rst_i), .frame_i(frame_i),
    .cond_i(!ptr_valid_i && !ptr_all_ones), .thr_i(LOP_DECLARE), .hit_o(hit_badptr)
  );
  vpd_persist #(.W(4)) u_ndf (
    .mclk_i(mclk_i), .rst_i(rst_i), .frame_i(frame_i),
    .cond_i(ndf_set_i && !ptr_all_ones), .thr_i(LOP_DECLARE), .hit_o(hit_ndf)
  );
  vpd_persist #(.W(4)) u_good (
    .mclk_i(mclk_i), .rst_i(rst_i), .frame_i(frame_i),
    .cond_i(ptr_valid_i && !ndf_set_i), .thr_i(PTR_CLEAR), .hit_o(hit_good)
  );
  vpd_persist #(.W(4)) u_ais (
    .mclk_i(mclk_i), .rst_i(rst_i), .frame_i(frame_i),
    .cond_i(ptr_all_ones && spe_ones_i), .thr_i(AIS_DECLARE), .hit_o(hit_ais)
  );
  vpd_persist #(.W(4)) u_aisclr (
    .mclk_i(mclk_i), .rst_i(rst_i), .frame_i(frame_i),
    .cond_i(ptr_valid_i), .thr_i(PTR_CLEAR), .hit_o(hit_aisclr)
  );

  // Unequipped and mismatch
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      uneq_q <= 1'b0; // R22
    end else if (frame_i) begin
      if (hit_zero && exp_label_q != LABEL_UNEQ) begin
        uneq_q <= 1'b1; // R1 R3
      end else if (hit_nonzero || exp_label_q == LABEL_UNEQ) begin
        uneq_q <= 1'b0; // R2 R3
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      plm_q <= 1'b0;
    end else if (frame_i) begin
      if (hit_zero && exp_label_q != LABEL_UNEQ) begin
        plm_q <= 1'b0; // R6
      end else begin
        plm_q <= ((label_accept ? c2_i : rx_label) != exp_label_q) && !uneq_q; // R5
      end
    end
  end

  // Remote defect and its instability
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdi_q <= 1'b0;
    end else if (frame_i) begin
      if (hit_rdi) begin
        rdi_q <= 1'b1; // R7 R8
      end else if (hit_nordi) begin
        rdi_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdi_val_q <= 3'h0;
      unst_q <= 4'h0;
      rdiu_q <= 1'b0;
    end else if (frame_i) begin
      rdi_val_q <= rdi_val;
      if (hit_same) begin
        unst_q <= 4'h0; // R11
        rdiu_q <= 1'b0;
      end else if (rdi_val != rdi_val_q) begin
        if (unst_q < thr) begin
          unst_q <= unst_q + 4'h1; // R10
        end
        if (unst_q + 4'h1 >= thr) begin
          rdiu_q <= 1'b1; // R10
        end
      end
    end
  end

  // Pointer loss and AU alarm indication
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lop_q <= 1'b0;
    end else if (frame_i) begin
      if (ptr_all_ones) begin
        lop_q <= 1'b0; // R16
      end else if (hit_badptr || hit_ndf) begin
        lop_q <= 1'b1; // R12
      end else if (hit_good) begin
        lop_q <= 1'b0; // R13
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ais_q <= 1'b0;
    end else if (frame_i) begin
      if (hit_ais) begin
        ais_q <= 1'b1; // R14 R16
      end else if (hit_aisclr) begin
        ais_q <= 1'b0; // R15
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      defect_o <= 6'h00;
    end else begin
      defect_o <= {uneq_q, plm_q, rdi_q, rdiu_q, lop_q, ais_q}; // R17
    end
  end

  // Register writes
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdi_cfg_q <= RST_RDI_CFG;
      exp_label_q <= RST_EXP_LABEL;
    end else if (cs_i && wr_i) begin
      if (addr_i == OFF_RDI_CFG) begin
        rdi_cfg_q <= wdata_i; // R9 R19
      end else if (addr_i == OFF_EXP_LABEL) begin
        exp_label_q <= wdata_i;
      end
    end
  end

  // Interrupt status byte two
  always_comb begin
    events = 8'h00;
    events[IS_CAIS] = concat_alarm_chg_i;
    events[IS_CLOP] = concat_ptr_loss_chg_i;
    events[IS_AISPTR] = frame_i && ptr_ones_i;
    events[IS_PTRCHG] = ptr_change_i;
    events[IS_POHCAP] = poh_capture_i;
    events[IS_TIM] = trace_mismatch_chg_i;
    events[IS_TRU] = trace_unstable_chg_i;
  end

  assign rd_stat = cs_i && rd_i && addr_i == OFF_INT_STAT2;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      int_stat_q <= RST_INT_STAT2; // R18
    end else if (rd_stat) begin
      int_stat_q <= events & IS_MASK; // R20 R21
    end else begin
      int_stat_q <= (int_stat_q | events) & IS_MASK; // R18
    end
  end

  // Read data, registered
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (cs_i && rd_i) begin
      if (addr_i == OFF_INT_STAT2) begin
        rdata_o <= int_stat_q; // R20
      end else if (addr_i == OFF_DEFECT_STAT0) begin
        rdata_o <= {2'b00, uneq_q, plm_q, rdi_q, rdiu_q, lop_q, ais_q}; // R17
      end else if (addr_i == OFF_RDI_CFG) begin
        rdata_o <= rdi_cfg_q;
      end else if (addr_i == OFF_RX_LABEL) begin
        rdata_o <= rx_label; // R4
      end else if (addr_i == OFF_EXP_LABEL) begin
        rdata_o <= exp_label_q;
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // Checks
  property p_uneq_exp_zero;
    @(posedge mclk_i) disable iff (rst_i)
      (exp_label_q == LABEL_UNEQ) |=> !uneq_q || $past(uneq_q);
  endproperty
  a_uneq_exp_zero: assert property (p_uneq_exp_zero) else $error("unequipped under zero label"); // R3

  property p_uneq_clears_plm;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(uneq_q) |-> !plm_q;
  endproperty
  a_uneq_clears_plm: assert property (p_uneq_clears_plm) else $error("mismatch kept on unequipped"); // R6

  property p_ais_over_lop;
    @(posedge mclk_i) disable iff (rst_i)
      (frame_i && ptr_all_ones) |=> !lop_q;
  endproperty
  a_ais_over_lop: assert property (p_ais_over_lop) else $error("pointer loss on all ones"); // R16

  property p_frame_only;
    @(posedge mclk_i) disable iff (rst_i)
      !frame_i |=> $stable(ais_q) && $stable(lop_q) && $stable(rdi_q);
  endproperty
  a_frame_only: assert property (p_frame_only) else $error("defect moved off frame"); // R22

  property p_read_clears;
    @(posedge mclk_i) disable iff (rst_i)
      (rd_stat && events == 8'h00) |=> int_stat_q == 8'h00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared on read"); // R20

  property p_event_kept;
    @(posedge mclk_i) disable iff (rst_i)
      (rd_stat && ptr_change_i) |=> int_stat_q[IS_PTRCHG];
  endproperty
  a_event_kept: assert property (p_event_kept) else $error("event lost on read"); // R21

  property p_bit7_zero;
    @(posedge mclk_i) disable iff (rst_i)
      1'b1 |-> !int_stat_q[7];
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("unused bit set"); // R18

  property p_plm_match;
    @(posedge mclk_i) disable iff (rst_i)
      (frame_i && (label_accept ? c2_i : rx_label) == exp_label_q) |=> !plm_q;
  endproperty
  a_plm_match: assert property (p_plm_match) else $error("mismatch on matching label"); // R5
endmodule
`default_nettype wire

// ===== rtl/vpd_persist.sv
/*
  Persistence counter: counts consecutive frames that meet a condition and
  reports when the count reaches a threshold. Saturates at the threshold.
  Assumes frame_i is a one-cycle pulse at the frame boundary.
*/
`timescale 1ns/100ps
`default_nettype none
module vpd_persist #(
  parameter int unsigned W = 4
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic frame_i,
  input wire logic cond_i,
  input wire logic [W-1:0] thr_i,
  output logic hit_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (frame_i) begin
      if (!cond_i) begin
        cnt_q <= '0;
      end else if (cnt_q < thr_i) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Hit includes the frame that completes the run
  assign hit_o = frame_i && cond_i && (cnt_q + 1'b1 >= thr_i || cnt_q >= thr_i);
endmodule
`default_nettype wire

// ===== rtl/vpd_pkg.sv
/*
  Package for the VC-4 path defect monitor: register offsets, field positions,
  reset values and persistence counts.
  Assumes an 8-bit microprocessor port with a 16-bit address.
*/
package vpd_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] OFF_INT_STAT2 = 16'h1189;
  localparam logic [15:0] OFF_DEFECT_STAT0 = 16'h1187;
  localparam logic [15:0] OFF_RDI_CFG = 16'h1193;
  localparam logic [15:0] OFF_RX_LABEL = 16'h1196;
  localparam logic [15:0] OFF_EXP_LABEL = 16'h1197;
  localparam logic [7:0] RST_INT_STAT2 = 8'h00;
  localparam logic [7:0] RST_RDI_CFG = 8'h05;
  localparam logic [7:0] RST_EXP_LABEL = 8'h02;
  localparam logic [7:0] RST_RX_LABEL = 8'h00;
  localparam logic [7:0] LABEL_UNEQ = 8'h00;
  // Mode select sits above the threshold nibble so the two never overlap
  localparam int unsigned RDI_TYPE_BIT = 4;
  localparam int unsigned RDI_THR_MSB = 3;
  localparam int unsigned ST_UNEQ = 5;
  localparam int unsigned ST_PLM = 4;
  localparam int unsigned ST_RDI = 3;
  localparam int unsigned ST_RDIU = 2;
  localparam int unsigned ST_LOP = 1;
  localparam int unsigned ST_AIS = 0;
  localparam int unsigned IS_CAIS = 6;
  localparam int unsigned IS_CLOP = 5;
  localparam int unsigned IS_AISPTR = 4;
  localparam int unsigned IS_PTRCHG = 3;
  localparam int unsigned IS_POHCAP = 2;
  localparam int unsigned IS_TIM = 1;
  localparam int unsigned IS_TRU = 0;
  localparam logic [7:0] IS_MASK = 8'h7f;
  localparam logic [3:0] LABEL_PERSIST = 4'h5;
  localparam logic [3:0] LOP_DECLARE = 4'h8;
  localparam logic [3:0] PTR_CLEAR = 4'h3;
  localparam logic [3:0] AIS_DECLARE = 4'h3;
endpackage
